//--- shared/sia_map.svh
`ifndef SIA_MAP_SVH
`define SIA_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SIA_ADR_STATUS    8'h00
`define SIA_ADR_ENABLE    8'h04
`define SIA_ADR_CFG       8'h08
`define SIA_ADR_TS        8'h0C
`define SIA_ADR_SWE_MASK  8'h10
`define SIA_ADR_SWE_PEND  8'h14
`define SIA_ADR_BM_MASK   8'h18
`define SIA_ADR_BM_PEND   8'h1C
`define SIA_ADR_MAC_MASK  8'h20
`define SIA_ADR_MAC_PEND  8'h24

// ----------------------------------------------------------------
// Top status / enable bit positions
// ----------------------------------------------------------------
`define SIA_BIT_SW        31
`define SIA_BIT_READY     30
`define SIA_BIT_TS        29
`define SIA_BIT_SWITCH    28
`define SIA_BIT_PHY2      27
`define SIA_BIT_PHY1      26
`define SIA_BIT_TIMER     19
`define SIA_BIT_PIN       12

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define SIA_CFG_OD        0
`define SIA_CFG_POL       4
`define SIA_CFG_EN        8
`define SIA_CFG_ASSERTED  12
`define SIA_CFG_HOLDOFF   13
`define SIA_CFG_DEAS_LSB  24
`define SIA_CFG_DEAS_W    8
`define SIA_TS_W          9
`define SIA_TS_EN_LSB     16
`define SIA_SWE_W         5
`define SIA_BM_W          2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define SIA_RST_READY     1'b1
`define SIA_RST_POL       1'b0
`define SIA_TICK_NS       10000
`define SIA_CLK_NS        5
`define SIA_TICK_CYC      ((`SIA_TICK_NS + `SIA_CLK_NS - 1) / `SIA_CLK_NS)
`define SIA_TICK_W        11

`endif

//--- shared/sia_pkg.sv
`include "sia_map.svh"
package sia_pkg;

  // Wishbone request and answer carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sia_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } sia_wb_rsp_t;

  // Output line phases, Gray coded along idle->asserted->holdoff
  typedef enum logic [1:0] {
    SIA_IDLE     = 2'b00,
    SIA_ASSERTED = 2'b01,
    SIA_HOLDOFF  = 2'b11
  } sia_line_t;

  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic                      sw_sts;
    logic                      ready_sts;
    logic                      timer_sts;
    logic [31:0]               top_en;
    logic                      irq_en;
    logic                      irq_pol;
    logic                      irq_od;
    logic [`SIA_CFG_DEAS_W-1:0] deas;
    logic [`SIA_TS_W-1:0]      ts_sts;
    logic [`SIA_TS_W-1:0]      ts_en;
    logic [`SIA_SWE_W-1:0]     swe_mask;
    logic [`SIA_BM_W-1:0]      bm_mask;
    logic [`SIA_BM_W-1:0]      bm_pend;
    sia_line_t                 line;
    logic [`SIA_CFG_DEAS_W-1:0] deas_cnt;
    logic [`SIA_TICK_W-1:0]    tick_cnt;
    logic                      pin;
    logic                      pin_oe;
  } sia_state_t;

endpackage

//--- hdl/sia_top.sv
`timescale 1ns/10ps
`include "sia_map.svh"
module sia_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire sia_pkg::sia_wb_req_t wb_req_i,
  output sia_pkg::sia_wb_rsp_t      wb_rsp_o,
  input  wire logic [8:0]           ts_event_i,
  input  wire logic [1:0]           bm_event_i,
  input  wire logic                 swe_irq_i,
  input  wire logic [1:0]           phy_irq_i,
  input  wire logic                 pin_irq_i,
  input  wire logic                 timer_wrap_i,
  output logic                      irq_o,
  output logic                      irq_oe_o
);
  import sia_pkg::*;

  localparam logic [`SIA_TICK_W-1:0] TICK_LAST =
    `SIA_TICK_W'(`SIA_TICK_CYC - 1);

  sia_state_t r;
  sia_state_t next_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        bus_hit;
  logic        wr;
  logic [31:0] wmask;
  logic [31:0] wdat;
  logic [31:0] clr;

  // Request taken on the first cycle only, ack answers next cycle
  assign bus_hit = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
  assign wr      = bus_hit & wb_req_i.we;
  assign wmask   = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                    {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  assign wdat    = wb_req_i.dat & wmask;
  assign clr     = wdat;

  // ----------------------------------------------------------------
  // Derived sources
  // ----------------------------------------------------------------
  logic [`SIA_SWE_W-1:0] swe_pend;
  logic [31:0]           status;
  logic                  any_src;
  logic                  want;
  logic                  deas_zero;

  // Switch middle tier: buffer manager, engine, MACs never pending
  always_comb begin
    swe_pend    = '0;
    swe_pend[0] = |(r.bm_pend & r.bm_mask);
    swe_pend[1] = swe_irq_i;
  end                                             // bits 4:2

  // Top status word, cascaded bits only mirror lower tiers
  always_comb begin
    status                  = '0;
    status[`SIA_BIT_SW]     = r.sw_sts;
    status[`SIA_BIT_READY]  = r.ready_sts;
    status[`SIA_BIT_TIMER]  = r.timer_sts;
    status[`SIA_BIT_TS]     = |(r.ts_sts & r.ts_en);
    status[`SIA_BIT_SWITCH] = |(swe_pend & r.swe_mask);
    status[`SIA_BIT_PHY2]   = phy_irq_i[1];
    status[`SIA_BIT_PHY1]   = phy_irq_i[0];
    status[`SIA_BIT_PIN]    = pin_irq_i;
  end

  // Each source gated by its own enable, all merged into one line
  assign any_src   = |(status & r.top_en);
  assign want      = r.irq_en & any_src;
  assign deas_zero = (r.deas == '0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r       = r;
    next_r.ack   = bus_hit;
    next_r.rdata = '0;

    // Read mux; unmapped and reserved words answer zero
    if (bus_hit && !wb_req_i.we) begin
      case (wb_req_i.adr)
        `SIA_ADR_STATUS:   next_r.rdata = status;
        `SIA_ADR_ENABLE:   next_r.rdata = r.top_en;
        `SIA_ADR_CFG: begin
          next_r.rdata[`SIA_CFG_OD]       = r.irq_od;
          next_r.rdata[`SIA_CFG_POL]      = r.irq_pol;
          next_r.rdata[`SIA_CFG_EN]       = r.irq_en;
          next_r.rdata[`SIA_CFG_ASSERTED] = (r.line == SIA_ASSERTED);
          next_r.rdata[`SIA_CFG_HOLDOFF]  = (r.line == SIA_HOLDOFF);
          next_r.rdata[`SIA_CFG_DEAS_LSB +: `SIA_CFG_DEAS_W] = r.deas;
        end
        `SIA_ADR_TS: begin
          next_r.rdata[`SIA_TS_W-1:0] = r.ts_sts;
          next_r.rdata[`SIA_TS_EN_LSB +: `SIA_TS_W] = r.ts_en;
        end
        `SIA_ADR_SWE_MASK: next_r.rdata[`SIA_SWE_W-1:0] = r.swe_mask;
        `SIA_ADR_SWE_PEND: next_r.rdata[`SIA_SWE_W-1:0] = swe_pend;
        `SIA_ADR_BM_MASK:  next_r.rdata[`SIA_BM_W-1:0] = r.bm_mask;
        `SIA_ADR_BM_PEND:  next_r.rdata[`SIA_BM_W-1:0] = r.bm_pend;
        default:           next_r.rdata = '0;     // MAC words
      endcase
    end

    // Writes: plain stores and write-one-to-clear flags
    if (wr) begin
      case (wb_req_i.adr)
        `SIA_ADR_STATUS: begin
          if (clr[`SIA_BIT_SW])    next_r.sw_sts    = 1'b0;
          if (clr[`SIA_BIT_READY]) next_r.ready_sts = 1'b0;
          if (clr[`SIA_BIT_TIMER]) next_r.timer_sts = 1'b0;
        end
        `SIA_ADR_ENABLE: begin
          next_r.top_en = (r.top_en & ~wmask) | wdat;
        end
        `SIA_ADR_CFG: begin
          if (wb_req_i.sel[0]) begin
            next_r.irq_od  = wb_req_i.dat[`SIA_CFG_OD];
            next_r.irq_pol = wb_req_i.dat[`SIA_CFG_POL];
          end
          if (wb_req_i.sel[1])
            next_r.irq_en = wb_req_i.dat[`SIA_CFG_EN];
          if (wb_req_i.sel[3])
            next_r.deas =
              wb_req_i.dat[`SIA_CFG_DEAS_LSB +: `SIA_CFG_DEAS_W];
        end
        `SIA_ADR_TS: begin
          next_r.ts_sts = r.ts_sts & ~clr[`SIA_TS_W-1:0];
          if (wb_req_i.sel[2])
            next_r.ts_en = wb_req_i.dat[`SIA_TS_EN_LSB +: `SIA_TS_W];
        end
        `SIA_ADR_SWE_MASK: begin
          if (wb_req_i.sel[0])
            next_r.swe_mask = wb_req_i.dat[`SIA_SWE_W-1:0];
        end
        `SIA_ADR_BM_MASK: begin
          if (wb_req_i.sel[0])
            next_r.bm_mask = wb_req_i.dat[`SIA_BM_W-1:0];
        end
        `SIA_ADR_BM_PEND: begin
          next_r.bm_pend = r.bm_pend & ~clr[`SIA_BM_W-1:0];
        end
        default: begin
          next_r.top_en = next_r.top_en;          // Reserved: ignored
        end
      endcase
    end

    // Hardware sets come after clears so a same-cycle event wins
    next_r.ts_sts  = next_r.ts_sts | ts_event_i;
    next_r.bm_pend = next_r.bm_pend | bm_event_i;
    if (timer_wrap_i)
      next_r.timer_sts = 1'b1;
    if (next_r.top_en[`SIA_BIT_SW] && !r.top_en[`SIA_BIT_SW])
      next_r.sw_sts = 1'b1;

    // Line phases; a drop of the line starts the holdoff unless the interval is zero
    next_r.tick_cnt = '0;
    case (r.line)
      SIA_IDLE: begin
        if (want)
          next_r.line = SIA_ASSERTED;
      end
      SIA_ASSERTED: begin
        if (!want) begin
          if (deas_zero) begin
            next_r.line = SIA_IDLE;
          end else begin
            next_r.line     = SIA_HOLDOFF;
            next_r.deas_cnt = r.deas;
          end
        end
      end
      SIA_HOLDOFF: begin
        // Ticks of fixed length; one tick per interval unit
        if (r.tick_cnt == TICK_LAST) begin
          next_r.tick_cnt = '0;
          next_r.deas_cnt = r.deas_cnt - 1'b1;
          if (r.deas_cnt == 8'h01)
            next_r.line = SIA_IDLE;
        end else begin
          next_r.tick_cnt = r.tick_cnt + 1'b1;
        end
      end
      default: begin
        next_r.line = SIA_IDLE;
      end
    endcase

    // Pin drive: open-drain pulls only while active, push-pull always
    if (next_r.irq_od) begin
      next_r.pin    = 1'b0;
      next_r.pin_oe = (next_r.line == SIA_ASSERTED);
    end else begin
      next_r.pin    = (next_r.line == SIA_ASSERTED) ~^ next_r.irq_pol;
      next_r.pin_oe = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Ready flag comes up set: registers are usable right after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r           <= '0;
      r.ready_sts <= `SIA_RST_READY;
      r.irq_pol   <= `SIA_RST_POL;
      r.line      <= SIA_IDLE;
      r.pin       <= ~`SIA_RST_POL;
      r.pin_oe    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign wb_rsp_o.ack = r.ack;
  assign wb_rsp_o.dat = r.rdata;
  assign irq_o        = r.pin;
  assign irq_oe_o     = r.pin_oe;

endmodule // sia_top

//--- tb/sia_sva.sv
`timescale 1ns/10ps
module sia_sva (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire sia_pkg::sia_wb_req_t wb_req_i,
  input wire sia_pkg::sia_wb_rsp_t wb_rsp_o,
  input wire logic [8:0]           ts_event_i,
  input wire logic [1:0]           bm_event_i,
  input wire logic                 swe_irq_i,
  input wire logic [1:0]           phy_irq_i,
  input wire logic                 pin_irq_i,
  input wire logic                 timer_wrap_i,
  input wire logic                 irq_o,
  input wire logic                 irq_oe_o
);
  import sia_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of the pin configuration
  // ----------------------------------------------------------------
  localparam int TICK = 2000;
  logic        od, pol, en, en_d, line_on;
  logic [7:0]  deas;
  logic [19:0] gap;
  logic        cfg_wr;
  assign cfg_wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we
                & !wb_rsp_o.ack & (wb_req_i.adr == 8'h08);
  // Pin style and polarity act on the pin at the write edge itself;
  // the enable only reaches the line one cycle later, so it alone is
  // delayed, else a polarity flip would look like a spurious request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {od, pol, en, en_d} <= '0;
      deas <= '0;
    end else begin
      if (cfg_wr && wb_req_i.sel[0]) begin
        pol <= wb_req_i.dat[4];
        od  <= wb_req_i.dat[0];
      end
      if (cfg_wr && wb_req_i.sel[1]) en <= wb_req_i.dat[8];
      if (cfg_wr && wb_req_i.sel[3]) deas <= wb_req_i.dat[31:24];
      en_d <= en;
    end
  end
  assign line_on = od ? irq_oe_o : (irq_o == pol);
  // Quiet-cycle count saturates, so a long idle spell never wraps
  always_ff @(posedge clk_i) begin
    if (rst_i) gap <= '1;
    else if (line_on) gap <= '0;
    else if (gap != '1) gap <= gap + 20'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_taken_s;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence rd_reserved_s;
    req_taken_s ##0 (!wb_req_i.we && wb_req_i.adr >= 8'h20);
  endsequence
  ack_latency_a: assert property (req_taken_s |=> wb_rsp_o.ack)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  rdata_idle_a: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == '0)
    else $error("read data outside ack");
  reserved_zero_a: assert property (rd_reserved_s |=> wb_rsp_o.dat == '0)
    else $error("reserved word not zero");
  od_pin_low_a: assert property (od |-> !irq_o)
    else $error("open drain drives high");
  push_pull_oe_a: assert property (!od |-> irq_oe_o)
    else $error("push pull not driving");
  disabled_quiet_a: assert property (!en_d |-> !line_on)
    else $error("line active while disabled");
  holdoff_gap_a: assert property ($rose(line_on) && deas != 8'h0
    |-> gap >= TICK * deas) else $error("reassert inside holdoff");
endmodule // sia_sva

//--- tb/sia_host.sv
`timescale 1ns/10ps
module sia_host (
  input  wire logic irq_o,
  input  wire logic irq_oe_o,
  input  wire logic pol_i,
  output logic      line_o,
  output logic      active_o
);
  // Released wire floats to the board pull-up, as on a shared line
  assign line_o   = irq_oe_o ? irq_o : 1'b1;
  // Host reads a request at the level it programmed
  assign active_o = (line_o == pol_i);
endmodule // sia_host

//--- tb/tb_system_interrupt_aggregator.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, a, b); end end
module tb_system_interrupt_aggregator;
  import sia_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  sia_wb_req_t req = '0;
  sia_wb_rsp_t rsp;
  logic [8:0]  ts_ev = '0, ev, en;
  logic [1:0]  bm_ev = '0;
  logic [3:0]  lv = '0;
  logic        tmr = 1'b0, pol = 1'b1;
  logic        irq, oe, line, act;
  logic [31:0] rd;
  int          fails = 0, samples_checked = 0, n;
  int          bits[4] = '{26, 27, 12, 28};
  always #2.5 clk_i = ~clk_i;
  sia_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .ts_event_i(ts_ev), .bm_event_i(bm_ev), .swe_irq_i(lv[3]),
    .phy_irq_i(lv[1:0]), .pin_irq_i(lv[2]), .timer_wrap_i(tmr),
    .irq_o(irq), .irq_oe_o(oe));
  sia_host host (.irq_o(irq), .irq_oe_o(oe), .pol_i(pol), .line_o(line),
    .active_o(act));
  function automatic logic [31:0] bit_at(input int b);
    return 32'h1 << b;
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // One classic cycle; released at the edge that sees ack
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, s, d};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
    wb(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask
  // Bounded wait for the host to see a request
  task automatic wait_act(output int c);
    c = 0;
    while (act !== 1'b1 && c < 3000) begin
      @(posedge clk_i);
      c++;
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under 10k cycles
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hC4A44E70));
    tick(2);
    rst_i <= 1'b0;
    rd_chk(8'h00, '1, bit_at(30));
    `CHK(irq, 1'b1)
    wb(1'b1, 8'h3C, '1);
    rd_chk(8'h3C, '1, 32'h0);
    wb(1'b1, 8'h24, '1);
    rd_chk(8'h24, '1, 32'h0);
    wb(1'b1, 8'h08, 32'h0000_0110);
    wb(1'b1, 8'h10, 32'h2);
    wb(1'b1, 8'h00, bit_at(30));
    rd_chk(8'h00, '1, 32'h0);
    // Level sources: masked first, then enabled, then withdrawn
    foreach (bits[k]) begin
      lv <= 4'h1 << k;
      tick(2);
      rd_chk(8'h00, '1, bit_at(bits[k]));
      `CHK(line, 1'b0)
      wb(1'b1, 8'h04, bit_at(bits[k]));
      tick(2);
      `CHK(line, 1'b1)
      lv <= '0;
      tick(2);
      rd_chk(8'h00, '1, 32'h0);
      `CHK(line, 1'b0)
      wb(1'b1, 8'h04, 32'h0);
    end
    wb(1'b1, 8'h04, bit_at(29));
    for (int k = 0; k < 4; k++) begin
      ev = (k == 0) ? 9'h1FF : 9'($urandom);
      en = (k == 0) ? 9'h100 : 9'($urandom);
      wb(1'b1, 8'h0C, {7'h0, en, 16'h0}, 4'hC);
      ts_ev <= ev;
      tick(1);
      ts_ev <= '0;
      tick(2);
      rd_chk(8'h0C, 32'h1FF, {23'h0, ev});
      rd_chk(8'h00, '1, |(ev & en) ? bit_at(29) : 32'h0);
      `CHK(line, |(ev & en))
      wb(1'b1, 8'h0C, {23'h0, ev}, 4'h3);
      rd_chk(8'h00, '1, 32'h0);
    end
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b1, 8'h10, 32'h1);
    wb(1'b1, 8'h04, bit_at(28));
    bm_ev <= 2'b10;
    tick(1);
    bm_ev <= 2'b00;
    tick(2);
    rd_chk(8'h1C, '1, 32'h2);
    `CHK(line, 1'b0)
    bm_ev <= 2'b01;
    tick(1);
    bm_ev <= 2'b00;
    tick(3);
    `CHK(line, 1'b1)
    rd_chk(8'h14, 32'h1D, 32'h1);
    wb(1'b1, 8'h1C, 32'h3);
    tick(2);
    `CHK(line, 1'b0)
    wb(1'b1, 8'h04, bit_at(19) | bit_at(31));
    tmr <= 1'b1;
    tick(1);
    tmr <= 1'b0;
    tick(2);
    rd_chk(8'h00, '1, bit_at(19) | bit_at(31));
    `CHK(line, 1'b1)
    wb(1'b1, 8'h00, bit_at(19) | bit_at(31));
    rd_chk(8'h00, '1, 32'h0);
    wb(1'b1, 8'h04, bit_at(12));
    lv <= 4'h4;
    tick(3);
    `CHK(line, 1'b1)
    wb(1'b1, 8'h08, 32'h0, 4'h2);
    tick(2);
    `CHK(line, 1'b0)
    pol <= 1'b0;
    wb(1'b1, 8'h08, 32'h100, 4'h3);
    tick(2);
    `CHK({irq, oe}, 2'b01)
    wb(1'b1, 8'h08, 32'h101, 4'h1);
    tick(2);
    `CHK({line, oe, act}, 3'b011)
    // Holdoff of one tick, entered by disable and by source loss
    wb(1'b1, 8'h08, 32'h0100_0000, 4'h8);
    for (int c = 0; c < 3; c++) begin
      wait_act(n);
      if (c == 2) wb(1'b1, 8'h08, 32'h0, 4'h8);
      if (c != 1) begin
        wb(1'b1, 8'h08, 32'h0, 4'h2);
        wb(1'b1, 8'h08, 32'h100, 4'h2);
      end else begin
        lv <= '0;
        tick(2);
        lv <= 4'h4;
        tick(2);
      end
      wait_act(n);
      if (c < 2) `CHK(n > 1980 && n < 2010, 1'b1)
      else `CHK(n < 4, 1'b1)
    end
    stop_test();
  end
endmodule // tb_system_interrupt_aggregator
bind sia_top sia_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .ts_event_i(ts_event_i), .bm_event_i(bm_event_i),
  .swe_irq_i(swe_irq_i), .phy_irq_i(phy_irq_i), .pin_irq_i(pin_irq_i),
  .timer_wrap_i(timer_wrap_i), .irq_o(irq_o), .irq_oe_o(irq_oe_o));
